/* File: shared/bsr_pkg.sv */
// shared constants for the battery backed sram with real-time clock
package bsr_pkg;
	localparam int ADDR_W = 13;
	localparam int DATA_W = 8;
	localparam int DEPTH = 8192;
	localparam logic [12:0] CLK_BASE = 13'h1ff8;
	localparam logic [2:0] IDX_CTRL = 3'h0;
	localparam logic [2:0] IDX_SEC = 3'h1;
	localparam logic [2:0] IDX_MIN = 3'h2;
	localparam logic [2:0] IDX_HOUR = 3'h3;
	localparam logic [2:0] IDX_DAY = 3'h4;
	localparam logic [2:0] IDX_DATE = 3'h5;
	localparam logic [2:0] IDX_MONTH = 3'h6;
	localparam logic [2:0] IDX_YEAR = 3'h7;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int CTRL_HALT_BIT = 6;
	localparam int CLK_HZ = 25000000;
	localparam int SEC_CYCLES = CLK_HZ;
	localparam int FT_HALF_CYCLES = CLK_HZ / 2;
	localparam logic [7:0] RESET_DATE = 8'h01;
	localparam logic [7:0] RESET_MONTH = 8'h01;
	localparam logic [7:0] RESET_DAY = 8'h01;
endpackage : bsr_pkg

/* File: shared/bsr_time_if.sv */
// time counter values passed from the calendar to the top
`timescale 1ns/1ps
interface bsr_time_if;
	logic [7:0] sec;
	logic [7:0] min;
	logic [7:0] hour;
	logic [7:0] day;
	logic [7:0] date;
	logic [7:0] month;
	logic [7:0] year;
	logic tick;
	modport src (output sec, min, hour, day, date, month, year, tick);
	modport dst (input sec, min, hour, day, date, month, year, tick);
endinterface : bsr_time_if

/* File: hdl/bsr_calendar.sv */
// bcd calendar counters advanced by a one-second enable
`timescale 1ns/1ps
module bsr_calendar (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sec_en,
	bsr_time_if.src t
);
	logic [7:0] sec, min, hour, day, date, month, year;
	logic [7:0] next_sec, next_min, next_hour, next_day, next_date, next_month, next_year;
	logic [7:0] last_date;
	logic leap;

	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		if (v[3:0] == 4'h9) begin
			bcd_inc = {v[7:4] + 4'h1, 4'h0};
		end else begin
			bcd_inc = {v[7:4], v[3:0] + 4'h1};
		end
	endfunction : bcd_inc

	always_comb begin
		// bcd year divisible by four: tens even with units 0/4/8, or tens odd with 2/6
		leap = (year[4] == 1'b0) ? (year[1:0] == 2'b00 && year[3:0] != 4'h4 ? 1'b1 :
			(year[3:0] == 4'h4 || year[3:0] == 4'h8)) : (year[3:0] == 4'h2 || year[3:0] == 4'h6);
		case (month)
			8'h02: last_date = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: last_date = 8'h30;
			default: last_date = 8'h31;
		endcase
	end

	always_comb begin
		next_sec = sec;
		next_min = min;
		next_hour = hour;
		next_day = day;
		next_date = date;
		next_month = month;
		next_year = year;
		if (sec_en) begin
			next_sec = bcd_inc(sec);
			if (sec == 8'h59) begin
				next_sec = 8'h00;
				next_min = bcd_inc(min);
				if (min == 8'h59) begin
					next_min = 8'h00;
					next_hour = bcd_inc(hour);
					if (hour == 8'h23) begin
						next_hour = 8'h00;
						next_day = (day == 8'h07) ? bsr_pkg::RESET_DAY : day + 8'h01;
						next_date = bcd_inc(date);
						if (date == last_date) begin
							next_date = bsr_pkg::RESET_DATE;
							next_month = bcd_inc(month);
							if (month == 8'h12) begin
								next_month = bsr_pkg::RESET_MONTH;
								next_year = (year == 8'h99) ? 8'h00 : bcd_inc(year);
							end
						end
					end
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sec <= 8'h00;
			min <= 8'h00;
			hour <= 8'h00;
			day <= bsr_pkg::RESET_DAY;
			date <= bsr_pkg::RESET_DATE;
			month <= bsr_pkg::RESET_MONTH;
			year <= 8'h00;
		end else begin
			sec <= next_sec;
			min <= next_min;
			hour <= next_hour;
			day <= next_day;
			date <= next_date;
			month <= next_month;
			year <= next_year;
		end
	end

	assign t.sec = sec;
	assign t.min = min;
	assign t.hour = hour;
	assign t.day = day;
	assign t.date = date;
	assign t.month = month;
	assign t.year = year;
	assign t.tick = sec_en;

	hour_range_a: assert property (@(posedge clk) disable iff (!rst_n) hour <= 8'h23)
		else $error("hour left 24 hour range");
	date_range_a: assert property (@(posedge clk) disable iff (!rst_n)
		date <= last_date && date != 8'h00)
		else $error("date beyond month length");
endmodule : bsr_calendar

/* File: hdl/bsr_sram_rtc.sv */
// battery backed 8k x 8 static memory with clock bytes at the top
//
// Function
// - 8192 by 8 memory on parallel bus
// - clock bytes at top eight addresses
// - bcd time fields, 24 hour format
// - month length and leap correction
// - lowest clock byte is control byte
// - clock bytes copied from counters each second unless halted or a write commits in the tick cycle
// - clock bytes use ordinary memory cycles
// - writes need no special timing, unlimited
// - out of tolerance supply blocks writes
// - battery keeps memory and clock running
// - open drain frequency test output
// - read when strobe high, selects active
// - 13 address bits pick one byte
// - write spans overlap of strobe and selects
`timescale 1ns/1ps
module bsr_sram_rtc #(
	parameter int SEC_CYCLES = bsr_pkg::SEC_CYCLES,
	parameter int FT_HALF_CYCLES = bsr_pkg::FT_HALF_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [12:0] addr_lines,
	input wire logic [7:0] byte_io_in,
	output logic [7:0] byte_io_out,
	output logic byte_io_oe,
	input wire logic select_low_active_n,
	input wire logic select_high_active,
	input wire logic out_enable_n,
	input wire logic write_n,
	input wire logic power_fail_threshold,
	input wire logic battery_switch_level,
	output logic freq_check_out_oe,
	output logic on_battery
);
	// pins arrive asynchronously, so each passes two flops first
	logic [12:0] a_s1, a_s2;
	logic [7:0] d_s1, d_s2;
	logic [5:0] c_s1, c_s2;
	logic sel, rd, wr_act, wr_prev, pf, bat;
	logic [7:0] mem [bsr_pkg::DEPTH];
	logic [7:0] ctrl, next_ctrl;
	logic [$clog2(SEC_CYCLES)-1:0] sec_cnt, next_sec_cnt;
	logic [$clog2(FT_HALF_CYCLES)-1:0] ft_cnt, next_ft_cnt;
	logic sec_en, ft_lvl, next_ft_lvl;
	logic [7:0] next_out;
	logic next_oe;
	logic [12:0] wr_addr;
	logic [7:0] wr_data;
	logic wr_commit;
	bsr_time_if tif ();

	function automatic logic is_clock(input logic [12:0] a);
		is_clock = (a[12:3] == bsr_pkg::CLK_BASE[12:3]);
	endfunction : is_clock

	always_ff @(posedge clk) begin
		a_s1 <= addr_lines;
		a_s2 <= a_s1;
		d_s1 <= byte_io_in;
		d_s2 <= d_s1;
		c_s1 <= {select_low_active_n, select_high_active, out_enable_n, write_n,
			power_fail_threshold, battery_switch_level};
		c_s2 <= c_s1;
	end

	always_comb begin
		pf = c_s2[1];
		bat = c_s2[0];
		sel = !c_s2[5] && c_s2[4] && !pf;
		rd = sel && c_s2[2];
		wr_act = sel && !c_s2[2];
		// commit at the end of the overlap, with address and data held stable
		wr_commit = wr_prev && !wr_act && !pf;
		next_oe = rd && !c_s2[3];
		next_out = mem[a_s2];
		sec_en = (sec_cnt == $bits(sec_cnt)'(SEC_CYCLES - 1));
		next_sec_cnt = sec_en ? '0 : sec_cnt + 1'b1;
		next_ft_cnt = (ft_cnt == $bits(ft_cnt)'(FT_HALF_CYCLES - 1)) ? '0 : ft_cnt + 1'b1;
		next_ft_lvl = (ft_cnt == $bits(ft_cnt)'(FT_HALF_CYCLES - 1)) ? !ft_lvl : ft_lvl;
		next_ctrl = ctrl;
		if (wr_commit && wr_addr == bsr_pkg::CLK_BASE) begin
			next_ctrl = wr_data;
		end
	end

	// timekeeping keeps counting through battery backup
	bsr_calendar u_cal (
		.clk(clk),
		.rst_n(rst_n),
		.sec_en(sec_en),
		.t(tif)
	);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sec_cnt <= '0;
			ft_cnt <= '0;
			ft_lvl <= 1'b0;
			ctrl <= bsr_pkg::CTRL_RESET;
			wr_prev <= 1'b0;
			wr_addr <= '0;
			wr_data <= '0;
			byte_io_out <= '0;
			byte_io_oe <= 1'b0;
			freq_check_out_oe <= 1'b0;
			on_battery <= 1'b0;
		end else begin
			sec_cnt <= next_sec_cnt;
			ft_cnt <= next_ft_cnt;
			ft_lvl <= next_ft_lvl;
			ctrl <= next_ctrl;
			wr_prev <= wr_act;
			if (wr_act) begin
				wr_addr <= a_s2;
				wr_data <= d_s2;
			end
			byte_io_out <= next_out;
			byte_io_oe <= next_oe;
			// pulls low in the second half period so the pin idles released out of reset
			freq_check_out_oe <= ft_lvl;
			on_battery <= bat;
		end
	end

	// memory has no reset apart from the control cell: contents are battery backed across power loss
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			// keep the control cell equal to the control register from reset on
			mem[bsr_pkg::CLK_BASE] <= bsr_pkg::CTRL_RESET;
		end else if (wr_commit) begin
			mem[wr_addr] <= wr_data;
		end else if (tif.tick && !ctrl[bsr_pkg::CTRL_HALT_BIT]) begin
			// copy suspended while halt bit set so reads see a steady snapshot
			mem[{bsr_pkg::CLK_BASE[12:3], bsr_pkg::IDX_SEC}] <= tif.sec;
			mem[{bsr_pkg::CLK_BASE[12:3], bsr_pkg::IDX_MIN}] <= tif.min;
			mem[{bsr_pkg::CLK_BASE[12:3], bsr_pkg::IDX_HOUR}] <= tif.hour;
			mem[{bsr_pkg::CLK_BASE[12:3], bsr_pkg::IDX_DAY}] <= tif.day;
			mem[{bsr_pkg::CLK_BASE[12:3], bsr_pkg::IDX_DATE}] <= tif.date;
			mem[{bsr_pkg::CLK_BASE[12:3], bsr_pkg::IDX_MONTH}] <= tif.month;
			mem[{bsr_pkg::CLK_BASE[12:3], bsr_pkg::IDX_YEAR}] <= tif.year;
		end
	end

	logic ctrl_is_clk;
	assign ctrl_is_clk = is_clock(wr_addr);

	pf_no_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		pf |-> !wr_commit)
		else $error("write committed during power fail");
	pf_float_a: assert property (@(posedge clk) disable iff (!rst_n)
		pf |=> !byte_io_oe)
		else $error("bus driven while power failed");
	write_float_a: assert property (@(posedge clk) disable iff (!rst_n)
		wr_act |=> !byte_io_oe)
		else $error("bus driven during write");
	read_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
		rd && !c_s2[3] |=> byte_io_oe && byte_io_out == $past(mem[a_s2]))
		else $error("read data missing");
	ctrl_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		wr_commit && wr_addr == bsr_pkg::CLK_BASE |=> ctrl == $past(wr_data))
		else $error("control byte not stored");
	ram_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		wr_commit && !ctrl_is_clk |=> mem[$past(wr_addr)] == $past(wr_data))
		else $error("memory write lost");
	sec_copy_a: assert property (@(posedge clk) disable iff (!rst_n)
		tif.tick && !wr_commit && !ctrl[bsr_pkg::CTRL_HALT_BIT]
		|=> mem[{bsr_pkg::CLK_BASE[12:3], bsr_pkg::IDX_SEC}] == $past(tif.sec))
		else $error("clock byte copy missed");
	battery_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
		bat |=> on_battery)
		else $error("battery state not shown");
	ft_toggle_a: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(ft_lvl) |=> $changed(freq_check_out_oe))
		else $error("frequency output not following");
	read_c: cover property (@(posedge clk) disable iff (!rst_n) rd && !c_s2[3]);
	write_c: cover property (@(posedge clk) disable iff (!rst_n) wr_commit);
	clkbyte_c: cover property (@(posedge clk) disable iff (!rst_n) wr_commit && ctrl_is_clk);
	pf_c: cover property (@(posedge clk) disable iff (!rst_n) wr_act ##1 pf);
endmodule : bsr_sram_rtc

/* File: testbench/bsr_host_model.sv */
// host bus master model for the parallel memory pins
`timescale 1ns/1ps
module bsr_host_model (
	input wire logic clk,
	output logic [12:0] addr_lines,
	output logic [7:0] host_d,
	output logic host_drv,
	output logic sel_n,
	output logic sel_h,
	output logic oe_n,
	output logic we_n,
	input wire logic [7:0] rd_data,
	input wire logic rd_oe
);
	initial begin
		addr_lines = 13'h0000;
		host_d = 8'h00;
		{host_drv, sel_n, sel_h, oe_n, we_n} = 5'h0f;
	end
	task automatic set_sel_h(input logic v);
		sel_h = v;
	endtask : set_sel_h
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	// output enable stays high so the bus is never driven by both sides
	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		step(1);
		addr_lines = a;
		host_d = d;
		host_drv = 1'b1;
		sel_n = 1'b0;
		we_n = 1'b0;
		step(4);
		we_n = 1'b1;
		// address and data held past the strobe edge
		step(4);
		sel_n = 1'b1;
		host_drv = 1'b0;
		step(3);
	endtask : wr
	task automatic rd(input logic [12:0] a, input logic en, output logic [7:0] d,
		output logic v);
		step(1);
		addr_lines = a;
		sel_n = 1'b0;
		oe_n = ~en;
		step(4);
		d = rd_data;
		v = rd_oe;
		oe_n = 1'b1;
		sel_n = 1'b1;
		step(4);
	endtask : rd
endmodule : bsr_host_model

/* File: testbench/tb_top.sv */
// self-checking bench for the memory with clock bytes
`timescale 1ns/1ps
module tb_top;
	logic clk, rst_n, pft, bat, host_drv, sel_n, sel_h, oe_n, we_n;
	logic oe, ft_oe, on_bat, v;
	logic [12:0] addr;
	logic [7:0] host_d, dout, pin, last, d, d2;
	int errors, n_checks, n;
	// a released bus shows the inverse of its last level, never a stale value
	assign pin = oe ? dout : (host_drv ? host_d : ~last);
	always @(posedge clk) last <= pin;
	bsr_sram_rtc #(.SEC_CYCLES(20), .FT_HALF_CYCLES(10)) dut_u (.clk(clk), .rst_n(rst_n),
		.addr_lines(addr), .byte_io_in(pin), .byte_io_out(dout), .byte_io_oe(oe),
		.select_low_active_n(sel_n), .select_high_active(sel_h), .out_enable_n(oe_n),
		.write_n(we_n), .power_fail_threshold(pft), .battery_switch_level(bat),
		.freq_check_out_oe(ft_oe), .on_battery(on_bat));
	bsr_host_model host_u (.clk(clk), .addr_lines(addr), .host_d(host_d),
		.host_drv(host_drv), .sel_n(sel_n), .sel_h(sel_h), .oe_n(oe_n), .we_n(we_n),
		.rd_data(dout), .rd_oe(oe));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic rc(input logic [12:0] a, input logic [7:0] exp);
		host_u.rd(a, 1'b1, d, v);
		chk({7'h00, v}, 8'h01);
		chk(d, exp);
	endtask : rc
	task automatic t_reset();
		chk({5'h00, oe, ft_oe, on_bat}, 8'h00);
		rc(13'h1ff8, 8'h00);
		$display("reset test done");
	endtask : t_reset
	task automatic t_mem();
		host_u.wr(13'h0000, 8'h11);
		host_u.wr(13'h0000, 8'h5a);
		host_u.wr(13'h1555, 8'h0f);
		host_u.wr(13'h1ff7, 8'ha5);
		rc(13'h0000, 8'h5a);
		rc(13'h1555, 8'h0f);
		rc(13'h1ff7, 8'ha5);
		host_u.rd(13'h1555, 1'b0, d, v);
		chk({7'h00, v}, 8'h00);
		host_u.set_sel_h(1'b0);
		host_u.rd(13'h1555, 1'b1, d, v);
		chk({7'h00, v}, 8'h00);
		host_u.set_sel_h(1'b1);
		$display("memory test done");
	endtask : t_mem
	task automatic t_power();
		pft = 1'b1;
		host_u.wr(13'h1555, 8'hf0);
		host_u.rd(13'h1555, 1'b1, d, v);
		chk({7'h00, v}, 8'h00);
		pft = 1'b0;
		bat = 1'b1;
		host_u.step(4);
		rc(13'h1555, 8'h0f);
		chk({7'h00, on_bat}, 8'h01);
		bat = 1'b0;
		host_u.step(4);
		chk({7'h00, on_bat}, 8'h00);
		$display("power test done");
	endtask : t_power
	task automatic t_clock();
		host_u.wr(13'h1ff8, 8'h40);
		host_u.wr(13'h1ff9, 8'h59);
		host_u.step(50);
		rc(13'h1ff9, 8'h59);
		host_u.wr(13'h1ff8, 8'h00);
		host_u.step(25);
		host_u.rd(13'h1ff9, 1'b1, d, v);
		host_u.step(25);
		host_u.rd(13'h1ff9, 1'b1, d2, v);
		chk({7'h00, d != d2}, 8'h01);
		chk({7'h00, d2[3:0] < 4'ha && d2 < 8'h60}, 8'h01);
		host_u.rd(13'h1ffb, 1'b1, d, v);
		chk({7'h00, d[3:0] < 4'ha && d < 8'h24}, 8'h01);
		n = 0;
		d = {7'h00, ft_oe};
		repeat (40) begin
			@(posedge clk);
			#1;
			if (ft_oe !== d[0]) n++;
			d[0] = ft_oe;
		end
		chk(n[7:0], 8'h04);
		$display("clock test done");
	endtask : t_clock
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : wrap_up
	initial begin
		#200000;
		errors++;
		wrap_up();
	end
	initial begin
		rst_n = 1'b0;
		pft = 1'b0;
		bat = 1'b0;
		errors = 0;
		n_checks = 0;
		repeat (4) @(posedge clk);
		#1;
		rst_n = 1'b1;
		host_u.step(3);
		t_reset();
		t_mem();
		t_power();
		t_clock();
		wrap_up();
	end
endmodule : tb_top
